// File: hdl/vpr_defs.svh
`ifndef VPR_DEFS_SVH
`define VPR_DEFS_SVH

// Register byte offsets.
`define VPR_OFS_MCR_A     8'h00
`define VPR_OFS_MCR_B     8'h04
`define VPR_OFS_DPC       8'h08
`define VPR_OFS_WDT       8'h0C
`define VPR_OFS_CMD       8'h10
`define VPR_OFS_STAT      8'h14

// Reset values.
`define VPR_MCR_RST       8'h00
`define VPR_DPC_RST       16'h0000
`define VPR_WDT_RST       16'h0000

// Port master control fields.
`define VPR_MCR_DIR       1:0
`define VPR_MCR_POL       2
`define VPR_MCR_FMT       4:3

// Datapath control fields.
`define VPR_DPC_SCL_SEL   1:0
`define VPR_DPC_SCL_QUAL  2
`define VPR_DPC_CLP_SEL   4:3
`define VPR_DPC_CLP_QUAL  5
`define VPR_DPC_OSYNC     7:6
`define VPR_DPC_ROUTE_A   8
`define VPR_DPC_ROUTE_B   9
`define VPR_DPC_D_BYPASS  10
`define VPR_DPC_GEN_PORT  12:11

// Watchdog control fields.
`define VPR_WDT_WATCHDOG_TIMEOUT_COUNT     9:0
`define VPR_WDT_RUN       10
`define VPR_WDT_FSRC      12:11
`define VPR_WDT_ILACE     13

// Command bits (write only, self clearing).
`define VPR_CMD_SW_FSYNC  0
`define VPR_CMD_CLR_LOST  1

// Status fields.
`define VPR_STAT_FID      0
`define VPR_STAT_TOGGLE   1
`define VPR_STAT_LOST     2
`define VPR_STAT_COUNT    25:16

// Watchdog prescale of the core clock.
`define VPR_WD_PRESCALE   49152

`endif

// File: hdl/vpr_pkg.sv
`default_nettype none

package vpr_pkg;

    // Port direction modes.
    typedef enum logic [1:0] {
        VPR_DIR_IN     = 2'b00,
        VPR_DIR_OUT    = 2'b01,
        VPR_DIR_PIXDUP = 2'b10,
        VPR_DIR_FLDDUP = 2'b11
    } vpr_dir_t;

    // Pixel formats; the 12-bit one is input only.
    typedef enum logic [1:0] {
        VPR_FMT_YC16  = 2'b00,
        VPR_FMT_YC12  = 2'b01,
        VPR_FMT_RGB16 = 2'b10,
        VPR_FMT_RGB8  = 2'b11
    } vpr_fmt_t;

    // Input processor stream sources.
    typedef enum logic [1:0] {
        VPR_SRC_A    = 2'b00,
        VPR_SRC_B    = 2'b01,
        VPR_SRC_OPU  = 2'b10,
        VPR_SRC_HOST = 2'b11
    } vpr_src_t;

    // Master field sync sources.
    typedef enum logic [1:0] {
        VPR_FS_A    = 2'b00,
        VPR_FS_B    = 2'b01,
        VPR_FS_WDOG = 2'b10,
        VPR_FS_SW   = 2'b11
    } vpr_fsync_t;

endpackage

`default_nettype wire

// File: hdl/vpr_top.sv
// The address-and-strobe port and the register offsets were chosen for this implementation.
`include "vpr_defs.svh"
`default_nettype none

module vpr_top #(
    parameter int PRESCALE = `VPR_WD_PRESCALE
) (
    // Clock and reset.
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    // Register port.
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [31:0] REG_RDATA,
    // Video port A.
    input  wire logic [15:0] PORT_A_DATA_I,
    output logic      [15:0] PORT_A_DATA_O,
    output logic             PORT_A_DATA_OE,
    input  wire logic        PORT_A_VS,
    input  wire logic        PORT_A_HS,
    input  wire logic        PORT_A_PIXEL_PHASE,
    output logic             PORT_A_INPUT_ENABLE_N,
    output vpr_pkg::vpr_fmt_t PORT_A_FMT,
    output logic             GEN_ATTACH_A,
    // Video port B.
    input  wire logic [15:0] PORT_B_DATA_I,
    output logic      [15:0] PORT_B_DATA_O,
    output logic             PORT_B_DATA_OE,
    input  wire logic        PORT_B_VS,
    input  wire logic        PORT_B_HS,
    input  wire logic        PORT_B_PIXEL_PHASE,
    output logic             PORT_B_INPUT_ENABLE_N,
    output vpr_pkg::vpr_fmt_t PORT_B_FMT,
    output logic             GEN_ATTACH_B,
    // Codec handshake on port B.
    input  wire logic        CODEC_STALL_REQUEST_N,
    output logic             CODEC_STALL_N,
    // Internal sync generator references.
    input  wire logic        GEN_VS,
    input  wire logic        GEN_HS,
    // Output processor stream.
    input  wire logic [15:0] OPU_DATA,
    input  wire logic        OPU_VALID,
    output logic             OPU_HOLD,
    output logic             OPU_SYNC_VS,
    output logic             OPU_SYNC_HS,
    // Scaling input processor feed.
    output logic      [15:0] SCL_DATA,
    output logic             SCL_VALID,
    output logic             SCL_VS,
    output logic             SCL_HS,
    input  wire logic        SCL_BUSY,
    // Clipping input processor feed and host bypass.
    input  wire logic [15:0] HOST_DATA,
    input  wire logic        HOST_VALID,
    output logic      [15:0] CLP_DATA,
    output logic             CLP_VALID,
    output logic             CLP_VS,
    output logic             CLP_HS,
    output logic             CLP_BYPASS,
    input  wire logic        CLP_BUSY,
    // FIFO D to host bypass.
    input  wire logic [15:0] FIFOD_DATA,
    input  wire logic        FIFOD_VALID,
    output logic      [15:0] HOST_RD_DATA,
    output logic             HOST_RD_VALID,
    // Field and watchdog status.
    output logic             FIELD_ID,
    output logic             FIELD_TOGGLE,
    output logic             WDOG_PULSE,
    output logic             SYNC_LOST
);
    import vpr_pkg::*;

    logic [7:0]  mcr_a_reg;
    logic [7:0]  mcr_b_reg;
    logic [15:0] dpc_reg;
    logic [15:0] wdt_reg;
    logic [15:0] pre_reg;
    logic [9:0]  cnt_reg;
    logic        run_q_reg;
    logic        a_vs_q_reg;
    logic        b_vs_q_reg;
    logic        fid_reg;
    logic        tog_reg;
    logic        lost_reg;
    logic        wd_pulse;
    logic        tick;
    logic        sw_fsync;
    logic        clr_lost;
    logic        a_vs_rise;
    logic        b_vs_rise;
    logic        master_evt;
    logic        port_sync_evt;
    logic        a_in_act;
    logic        b_in_act;
    vpr_dir_t    dir_a;
    vpr_dir_t    dir_b;
    vpr_src_t    scl_sel;
    vpr_src_t    clp_sel;
    vpr_fsync_t  fsrc;

    assign dir_a   = vpr_dir_t'(mcr_a_reg[`VPR_MCR_DIR]);
    assign dir_b   = vpr_dir_t'(mcr_b_reg[`VPR_MCR_DIR]);
    assign scl_sel = vpr_src_t'(dpc_reg[`VPR_DPC_SCL_SEL]);
    assign clp_sel = vpr_src_t'(dpc_reg[`VPR_DPC_CLP_SEL]);
    assign fsrc    = vpr_fsync_t'(wdt_reg[`VPR_WDT_FSRC]);

    // Software writes of control registers.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mcr_a_reg <= `VPR_MCR_RST;
            mcr_b_reg <= `VPR_MCR_RST;
            dpc_reg   <= `VPR_DPC_RST;
            wdt_reg   <= `VPR_WDT_RST;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `VPR_OFS_MCR_A: mcr_a_reg <= REG_WDATA[7:0];
                `VPR_OFS_MCR_B: mcr_b_reg <= REG_WDATA[7:0];
                `VPR_OFS_DPC:   dpc_reg   <= REG_WDATA[15:0];
                `VPR_OFS_WDT:   wdt_reg   <= REG_WDATA[15:0];
                default:        ;
            endcase
        end
    end

    // Command strobes last only the write cycle.
    assign sw_fsync = REG_WR && REG_ADDR == `VPR_OFS_CMD
                      && REG_WDATA[`VPR_CMD_SW_FSYNC];
    assign clr_lost = REG_WR && REG_ADDR == `VPR_OFS_CMD
                      && REG_WDATA[`VPR_CMD_CLR_LOST];

    // Read data stands in the cycle after the strobe; unmapped reads zero.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0000_0000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `VPR_OFS_MCR_A: REG_RDATA <= {24'h000000, mcr_a_reg};
                `VPR_OFS_MCR_B: REG_RDATA <= {24'h000000, mcr_b_reg};
                `VPR_OFS_DPC:   REG_RDATA <= {16'h0000, dpc_reg};
                `VPR_OFS_WDT:   REG_RDATA <= {16'h0000, wdt_reg};
                `VPR_OFS_STAT:  REG_RDATA <= {6'h00, cnt_reg, 13'h0000,
                                              lost_reg, tog_reg, fid_reg};
                default:        REG_RDATA <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA <= 32'h0000_0000;
        end
    end

    // Input enables per direction mode.
    // direction modes
    always_comb begin
        case (dir_a)
            VPR_DIR_IN:  PORT_A_INPUT_ENABLE_N = 1'b0;
            VPR_DIR_OUT: PORT_A_INPUT_ENABLE_N = 1'b1;
            default:     PORT_A_INPUT_ENABLE_N =
                             PORT_A_PIXEL_PHASE ^ mcr_a_reg[`VPR_MCR_POL];
        endcase
        case (dir_b)
            VPR_DIR_IN:  PORT_B_INPUT_ENABLE_N = 1'b0;
            VPR_DIR_OUT: PORT_B_INPUT_ENABLE_N = 1'b1;
            default:     PORT_B_INPUT_ENABLE_N =
                             PORT_B_PIXEL_PHASE ^ mcr_b_reg[`VPR_MCR_POL];
        endcase
    end
    assign a_in_act = !PORT_A_INPUT_ENABLE_N;
    assign b_in_act = !PORT_B_INPUT_ENABLE_N;

    // Generator attach comes from one field, so both can never be set.
    // single attach
    assign GEN_ATTACH_A = dpc_reg[`VPR_DPC_GEN_PORT] == 2'b01;
    assign GEN_ATTACH_B = dpc_reg[`VPR_DPC_GEN_PORT] == 2'b10;

    // Port formats; a 12-bit request on an output-only port becomes 16-bit.
    // format coercion
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PORT_A_FMT <= VPR_FMT_YC16;
            PORT_B_FMT <= VPR_FMT_YC16;
        end else begin
            PORT_A_FMT <= (dir_a == VPR_DIR_OUT
                           && mcr_a_reg[`VPR_MCR_FMT] == VPR_FMT_YC12)
                          ? VPR_FMT_YC16 : vpr_fmt_t'(mcr_a_reg[`VPR_MCR_FMT]);
            PORT_B_FMT <= (dir_b == VPR_DIR_OUT
                           && mcr_b_reg[`VPR_MCR_FMT] == VPR_FMT_YC12)
                          ? VPR_FMT_YC16 : vpr_fmt_t'(mcr_b_reg[`VPR_MCR_FMT]);
        end
    end

    // Output buffers drive the processor stream when routed and not in input phase.
    // output routing
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            PORT_A_DATA_O  <= 16'h0000;
            PORT_B_DATA_O  <= 16'h0000;
            PORT_A_DATA_OE <= 1'b0;
            PORT_B_DATA_OE <= 1'b0;
        end else begin
            PORT_A_DATA_O  <= OPU_DATA;
            PORT_B_DATA_O  <= OPU_DATA;
            PORT_A_DATA_OE <= dpc_reg[`VPR_DPC_ROUTE_A] && !a_in_act;
            PORT_B_DATA_OE <= dpc_reg[`VPR_DPC_ROUTE_B] && !b_in_act;
        end
    end

    // Codec pacing on port B.
    // codec handshake
    assign OPU_HOLD      = dpc_reg[`VPR_DPC_ROUTE_B] && !CODEC_STALL_REQUEST_N;
    assign CODEC_STALL_N = !(b_in_act && (SCL_BUSY || CLP_BUSY));

    // Output processor sync source.
    // output sync select
    always_comb begin
        case (dpc_reg[`VPR_DPC_OSYNC])
            2'b01: begin
                OPU_SYNC_VS = PORT_A_VS;
                OPU_SYNC_HS = PORT_A_HS;
            end
            2'b10: begin
                OPU_SYNC_VS = PORT_B_VS;
                OPU_SYNC_HS = PORT_B_HS;
            end
            default: begin
                OPU_SYNC_VS = GEN_VS;
                OPU_SYNC_HS = GEN_HS;
            end
        endcase
    end

    // FIFO D to host bypass.
    // host bypass
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            HOST_RD_DATA  <= 16'h0000;
            HOST_RD_VALID <= 1'b0;
        end else begin
            HOST_RD_DATA  <= FIFOD_DATA;
            HOST_RD_VALID <= FIFOD_VALID && dpc_reg[`VPR_DPC_D_BYPASS];
        end
    end

    // Scaler input multiplexer.
    // scaler mux
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            SCL_DATA  <= 16'h0000;
            SCL_VALID <= 1'b0;
            SCL_VS    <= 1'b0;
            SCL_HS    <= 1'b0;
        end else begin
            case (scl_sel)
                VPR_SRC_A: begin
                    SCL_DATA  <= PORT_A_DATA_I;
                    SCL_VALID <= a_in_act && (PORT_A_PIXEL_PHASE
                                 || !dpc_reg[`VPR_DPC_SCL_QUAL]);
                    SCL_VS    <= PORT_A_VS;
                    SCL_HS    <= PORT_A_HS;
                end
                VPR_SRC_B: begin
                    SCL_DATA  <= PORT_B_DATA_I;
                    SCL_VALID <= b_in_act && (PORT_B_PIXEL_PHASE
                                 || !dpc_reg[`VPR_DPC_SCL_QUAL]);
                    SCL_VS    <= PORT_B_VS;
                    SCL_HS    <= PORT_B_HS;
                end
                default: begin
                    SCL_DATA  <= OPU_DATA;
                    SCL_VALID <= OPU_VALID;
                    SCL_VS    <= GEN_VS;
                    SCL_HS    <= GEN_HS;
                end
            endcase
        end
    end

    // Clipper input multiplexer, with host data going straight to its FIFO.
    // clipper mux
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CLP_DATA   <= 16'h0000;
            CLP_VALID  <= 1'b0;
            CLP_VS     <= 1'b0;
            CLP_HS     <= 1'b0;
            CLP_BYPASS <= 1'b0;
        end else begin
            CLP_BYPASS <= clp_sel == VPR_SRC_HOST;
            case (clp_sel)
                VPR_SRC_A: begin
                    CLP_DATA  <= PORT_A_DATA_I;
                    CLP_VALID <= a_in_act && (PORT_A_PIXEL_PHASE
                                 || !dpc_reg[`VPR_DPC_CLP_QUAL]);
                    CLP_VS    <= PORT_A_VS;
                    CLP_HS    <= PORT_A_HS;
                end
                VPR_SRC_B: begin
                    CLP_DATA  <= PORT_B_DATA_I;
                    CLP_VALID <= b_in_act && (PORT_B_PIXEL_PHASE
                                 || !dpc_reg[`VPR_DPC_CLP_QUAL]);
                    CLP_VS    <= PORT_B_VS;
                    CLP_HS    <= PORT_B_HS;
                end
                VPR_SRC_OPU: begin
                    CLP_DATA  <= OPU_DATA;
                    CLP_VALID <= OPU_VALID;
                    CLP_VS    <= GEN_VS;
                    CLP_HS    <= GEN_HS;
                end
                default: begin
                    CLP_DATA  <= HOST_DATA;
                    CLP_VALID <= HOST_VALID;
                    CLP_VS    <= 1'b0;
                    CLP_HS    <= 1'b0;
                end
            endcase
        end
    end

    // Vertical sync edge detection on the port inputs.
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            a_vs_q_reg <= 1'b0;
            b_vs_q_reg <= 1'b0;
        end else begin
            a_vs_q_reg <= PORT_A_VS;
            b_vs_q_reg <= PORT_B_VS;
        end
    end
    assign a_vs_rise = PORT_A_VS && !a_vs_q_reg;
    assign b_vs_rise = PORT_B_VS && !b_vs_q_reg;

    // Master field sync selection.
    // field sync select
    always_comb begin
        case (fsrc)
            VPR_FS_A:    master_evt = a_vs_rise;
            VPR_FS_B:    master_evt = b_vs_rise;
            VPR_FS_WDOG: master_evt = wd_pulse;
            default:     master_evt = sw_fsync;
        endcase
    end
    assign port_sync_evt = (fsrc == VPR_FS_A && a_vs_rise)
                           || (fsrc == VPR_FS_B && b_vs_rise);

    // Field id from horizontal sync level at a port vertical edge, flips on other sources, zero when progressive; toggle flips.
    // field logic
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            fid_reg <= 1'b0;
            tog_reg <= 1'b0;
        end else begin
            if (master_evt) begin
                tog_reg <= !tog_reg;
            end
            if (!wdt_reg[`VPR_WDT_ILACE]) begin
                fid_reg <= 1'b0;
            end else if (master_evt) begin
                case (fsrc)
                    VPR_FS_A: fid_reg <= PORT_A_HS;
                    VPR_FS_B: fid_reg <= PORT_B_HS;
                    default:  fid_reg <= !fid_reg;
                endcase
            end
        end
    end
    assign FIELD_ID     = fid_reg;
    assign FIELD_TOGGLE = tog_reg;

    // Prescaler produces one tick every PRESCALE clocks while running.
    // prescaler tick
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || !wdt_reg[`VPR_WDT_RUN]) begin
            pre_reg <= 16'h0000;
        end else if (tick) begin
            pre_reg <= 16'h0000;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end
    assign tick = wdt_reg[`VPR_WDT_RUN] && pre_reg == 16'(PRESCALE - 1);

    // Timeout counter; a port sync restarts it, expiry pulses and reloads.
    // watchdog counter
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            cnt_reg   <= 10'h000;
            run_q_reg <= 1'b0;
        end else begin
            run_q_reg <= wdt_reg[`VPR_WDT_RUN];
            if (wdt_reg[`VPR_WDT_RUN] && !run_q_reg) begin
                cnt_reg <= wdt_reg[`VPR_WDT_WATCHDOG_TIMEOUT_COUNT];
            end else if (port_sync_evt || wd_pulse) begin
                cnt_reg <= wdt_reg[`VPR_WDT_WATCHDOG_TIMEOUT_COUNT];
            end else if (tick && cnt_reg != 10'h000) begin
                cnt_reg <= cnt_reg - 10'h001;
            end
        end
    end
    assign wd_pulse = tick && run_q_reg && cnt_reg <= 10'h001;
    assign WDOG_PULSE = wd_pulse;

    // Sync loss is sticky; a new loss wins over a clear in the same cycle.
    // sync loss flag
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            lost_reg <= 1'b0;
        end else if (wd_pulse && (fsrc == VPR_FS_A || fsrc == VPR_FS_B)) begin
            lost_reg <= 1'b1;
        end else if (clr_lost) begin
            lost_reg <= 1'b0;
        end
    end
    assign SYNC_LOST = lost_reg;

    property p_in_only;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        dir_a == VPR_DIR_IN |-> !PORT_A_INPUT_ENABLE_N;
    endproperty
    a_in_only: assert property (p_in_only)
        else $error("input only port A enable not low");

    property p_out_only;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        dir_b == VPR_DIR_OUT |-> PORT_B_INPUT_ENABLE_N && !b_in_act;
    endproperty
    a_out_only: assert property (p_out_only)
        else $error("output only port B enable not high");

    property p_duplex;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        dir_a[1] |-> PORT_A_INPUT_ENABLE_N ==
                     (PORT_A_PIXEL_PHASE ^ mcr_a_reg[`VPR_MCR_POL]);
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("duplex enable does not follow pixel phase");

    property p_attach;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !(GEN_ATTACH_A && GEN_ATTACH_B);
    endproperty
    a_attach: assert property (p_attach)
        else $error("both ports attached to sync generator");

    property p_fid_zero;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !wdt_reg[`VPR_WDT_ILACE] |=> !FIELD_ID;
    endproperty
    a_fid_zero: assert property (p_fid_zero)
        else $error("field id not zero for progressive stream");

    property p_toggle;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (fsrc == VPR_FS_SW && sw_fsync) |=> FIELD_TOGGLE != $past(tog_reg);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("software field sync did not toggle");

    property p_wd_pulse;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        WDOG_PULSE |=> !WDOG_PULSE ##0 cnt_reg == $past(wdt_reg[9:0]);
    endproperty
    a_wd_pulse: assert property (p_wd_pulse)
        else $error("watchdog pulse not single or counter not reloaded");

    property p_reload;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        $rose(wdt_reg[`VPR_WDT_RUN]) |=> cnt_reg == $past(wdt_reg[9:0]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("re-enable did not reload the timeout");

    property p_opu_sync;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        scl_sel == VPR_SRC_OPU |=> SCL_VS == $past(GEN_VS)
                                   && SCL_VALID == $past(OPU_VALID);
    endproperty
    a_opu_sync: assert property (p_opu_sync)
        else $error("scaler fed by output processor without generator sync");

    property p_no_out12;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        dir_a == VPR_DIR_OUT |=> PORT_A_FMT != VPR_FMT_YC12;
    endproperty
    a_no_out12: assert property (p_no_out12)
        else $error("12-bit format offered on output port");

endmodule

`default_nettype wire

// File: bench/vpr_codec_model.sv
`default_nettype none
module vpr_codec_model (
    // Clock and pace.
    input  wire logic clk,
    input  wire logic slow,
    // Stall handshake.
    input  wire logic stall_n,
    output var  logic stall_req_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt = 2'h0;
    initial stall_req_n = 1'b1;
    // codec drives handshake
    // A slow codec asks for a hold two cycles out of four.
    always @(posedge clk) begin
        cnt <= cnt + 2'h1;
        stall_req_n <= ~(slow & cnt[1] & stall_n);
    end
endmodule
`default_nettype wire

// File: bench/tb_vpr_top.sv
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
 num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_vpr_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst = 1'b1, w = 1'b0, r = 1'b0, ph = 1'b0;
    logic        slow = 1'b0, sreq_n, stall_n, en_n, pls, tog, hold;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rdat, q;
    logic [15:0] da = 16'h0, db = 16'h0, scl;
    logic        vs = 1'b0, hs = 1'b0, field_id, lost, en_b_n, paoe, byp, hrv;
    logic        att_a, att_b, osv;
    logic [1:0]  fmt_a;
    logic [15:0] pao, clp, hrd;
    int          num_errors = 0, cmp_count = 0, n;
    vpr_top #(.PRESCALE(4)) i_dut (.CORE_CLK(clk), .SYS_RST(rst),
        .REG_ADDR(adr), .REG_WDATA(wd), .REG_WR(w), .REG_RD(r),
        .REG_RDATA(rdat), .PORT_A_DATA_I(da), .PORT_A_DATA_O(pao),
        .PORT_A_DATA_OE(paoe), .PORT_A_VS(vs), .PORT_A_HS(hs),
        .PORT_A_PIXEL_PHASE(ph), .PORT_A_INPUT_ENABLE_N(en_n),
        .PORT_A_FMT(fmt_a), .GEN_ATTACH_A(att_a), .PORT_B_DATA_I(db),
        .PORT_B_DATA_O(), .PORT_B_DATA_OE(), .PORT_B_VS(1'b0),
        .PORT_B_HS(1'b0), .PORT_B_PIXEL_PHASE(ph),
        .PORT_B_INPUT_ENABLE_N(en_b_n), .PORT_B_FMT(), .GEN_ATTACH_B(att_b),
        .CODEC_STALL_REQUEST_N(sreq_n), .CODEC_STALL_N(stall_n),
        .GEN_VS(ph), .GEN_HS(ph), .OPU_DATA(~da), .OPU_VALID(ph),
        .OPU_HOLD(hold), .OPU_SYNC_VS(osv), .OPU_SYNC_HS(), .SCL_DATA(scl),
        .SCL_VALID(), .SCL_VS(), .SCL_HS(), .SCL_BUSY(ph),
        .HOST_DATA(db), .HOST_VALID(ph), .CLP_DATA(clp), .CLP_VALID(),
        .CLP_VS(), .CLP_HS(), .CLP_BYPASS(byp), .CLP_BUSY(ph),
        .FIFOD_DATA(da), .FIFOD_VALID(ph), .HOST_RD_DATA(hrd),
        .HOST_RD_VALID(hrv), .FIELD_ID(field_id), .FIELD_TOGGLE(tog),
        .WDOG_PULSE(pls), .SYNC_LOST(lost));
    vpr_codec_model i_codec (.clk(clk), .slow(slow), .stall_n(stall_n),
        .stall_req_n(sreq_n));
    initial forever #20 clk = ~clk;
    // Register bus cycles.
    task reg_w(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {adr, wd, w} <= {a, d, 1'b1};
        @(posedge clk) w <= 1'b0;
    endtask
    task reg_r(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) {adr, r} <= {a, 1'b1};
        @(posedge clk) r <= 1'b0;
        #1 d = rdat;
    endtask
    // Waits for the next watchdog pulse, counting cycles.
    task wait_pulse;
        n = 0;
        do begin
            @(posedge clk) #1 n++;
        end while (pls !== 1'b1 && n < 100);
    endtask
    // Input enable for every direction, polarity and phase.
    task t_dir;
        for (int i = 0; i < 16; i++) begin
            reg_w(8'h00, {29'h0, i[2:0]});
            ph <= i[3];
            @(posedge clk) #1;
            `CHK("en_n", i[1] ? i[2] ^ i[3] : i[0], en_n)
        end
    endtask
    // Scaler source selection and register readback.
    task t_mux;
        da <= 16'hA5C3;
        db <= 16'h3C5A;
        for (int i = 0; i < 3; i++) begin
            reg_w(8'h08, i);
            repeat (2) @(posedge clk);
            #1 `CHK("scl", i == 0 ? da : i == 1 ? db : ~da, scl)
        end
        reg_r(8'h08, q);
        `CHK("dpc", 32'h2, q)
        reg_r(8'h40, q);
        `CHK("unmapped", 32'h0, q)
    endtask
    // Watchdog period, field toggle per event, software sync.
    task t_wdog;
        reg_w(8'h0C, 32'h1402);
        wait_pulse;
        wait_pulse;
        q[0] = tog;
        `CHK("period", 8, n)
        @(posedge clk) #1;
        `CHK("toggle", ~q[0], tog)
        reg_w(8'h0C, 32'h1800);
        q[0] = tog;
        reg_w(8'h10, 32'h1);
        @(posedge clk) #1;
        `CHK("sw_toggle", ~q[0], tog)
    endtask
    // Interlaced field id from port A, then sync loss and its clear.
    task t_field;
        reg_w(8'h0C, 32'h2402);
        {vs, hs} <= 2'b11;
        @(posedge clk) vs <= 1'b0;
        #1 `CHK("fid", 1'b1, field_id)
        wait_pulse;
        @(posedge clk) #1;
        `CHK("lost", 1'b1, lost)
        reg_w(8'h10, 32'h2);
        #1 `CHK("lost_clr", 1'b0, lost)
    endtask
    // Output routing, clipper host path, bypass, attach and formats.
    task t_route;
        `CHK("stall_n", 1'b0, stall_n)
        reg_w(8'h04, 32'h1);
        reg_w(8'h00, 32'h9);
        reg_w(8'h08, 32'hD58);
        repeat (2) @(posedge clk);
        #1 `CHK("en_b_n", 1'b1, en_b_n)
        `CHK("stall_n_out", 1'b1, stall_n)
        `CHK("fmt_a", 2'h0, fmt_a)
        `CHK("port_a_out", {1'b1, ~da}, {paoe, pao})
        `CHK("clp_host", {1'b1, db}, {byp, clp})
        `CHK("host_rd", {ph, da}, {hrv, hrd})
        `CHK("opu_vs", 1'b0, osv)
        `CHK("attach", 2'b10, {att_a, att_b})
    endtask
    // Codec hold follows the stall request on port B.
    task t_codec;
        reg_w(8'h08, 32'h200);
        slow <= 1'b1;
        repeat (6) begin
            @(posedge clk) #1;
            `CHK("hold", ~sreq_n, hold)
        end
    endtask
    task finish_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #100us num_errors++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 `CHK("rst_en_n", 1'b0, en_n)
        t_dir;
        t_mux;
        t_wdog;
        t_field;
        t_route;
        t_codec;
        finish_test;
    end
endmodule
`default_nettype wire
